// [src/smrlro_delay_mem.sv]
// small circular memory that delays a word by a programmable clock count
`timescale 1ns/1ps
module smrlro_delay_mem #(
    parameter int WIDTH = 2
) (
    // clock and control
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // data
    input  wire logic [3:0]       delay,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:15];
    logic [3:0]       ptr;
    wire  [3:0]       rd_addr = 4'(ptr - delay + 4'h1);
    wire              direct  = (delay == 4'h1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= 4'h0;
        end else if (ce) begin
            ptr <= 4'(ptr + 4'h1);
        end
    end

    // reset clears stale words so no false release appears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                mem[i] <= '0;
            end
        end else if (ce) begin
            mem[ptr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= direct ? wr_data : mem[rd_addr];
        end
    end
endmodule : smrlro_delay_mem

// [src/smrlro_mode_regs.sv]
// mode register decode, latency release, self refresh rate and termination
//
// Functional notes
// - leveling bit enables write leveling mode
// - additive latency: zero, cl minus one, cl minus two
// - column commands held by additive latency
// - read data after additive plus cas latency
// - write data after additive plus write latency
// - second register loaded only by mode set
// - write cas latency from bits five to three
// - automatic rate doubles above normal temperature
// - forced rate bit always gives double rate
// - both rate bits clear: single rate
// - nonzero write termination select enables dynamic
// - write termination during burst, nominal or off after
// - nominal and write termination act independently
// - no dynamic termination during write leveling
// - third register loaded by mode set, held
// - pattern mode bits ignored in normal operation
// - pattern select bit routes reads to pattern
// - bank address picks the mode register
`timescale 1ns/1ps
`include "smrlro_params.svh"
module smrlro_mode_regs
    import smrlro_pkg::*;
(
    // clock, reset and enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // command pins
    input  wire logic        cs_b,
    input  wire logic        ras_b,
    input  wire logic        cas_b,
    input  wire logic        we_b,
    input  wire logic [2:0]  ba,
    input  wire logic [17:0] addr,
    // case temperature above normal limit, pin
    input  wire logic        temp_hot,
    // settings from the base and first registers, same clock
    input  wire logic [3:0]  read_cas_latency,
    input  wire logic        nominal_termination_en,
    // mode outputs
    output logic             write_leveling,
    output logic [3:0]       additive_latency,
    output logic [3:0]       write_cas_latency,
    output logic             write_cas_unsupported,
    output logic [4:0]       total_read_latency,
    output logic [4:0]       total_write_latency,
    output logic [17:0]      extended_mode_two,
    output logic [17:0]      extended_mode_three,
    // self refresh rate
    output logic             selfrefresh_double,
    // termination
    output logic             dynamic_termination_en,
    output logic [1:0]       write_termination,
    output smrlro_term_type  termination_select,
    // column release and data timing
    output logic             released_read,
    output logic             released_write,
    output logic             read_data_start,
    output logic             write_data_start,
    // pattern register
    output logic             calibration_pattern_register,
    output logic [1:0]       pattern_mode,
    output logic             pattern_read
);
    // reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // pin synchronisers
    logic [25:0] pin_meta;
    logic [25:0] pin_sync;
    wire  [25:0] pin_raw = {temp_hot, cs_b, ras_b, cas_b, we_b, ba, addr};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 26'h1e00000;
            pin_sync <= 26'h1e00000;
        end else if (ce) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    wire        hot_s   = pin_sync[25];
    wire [3:0]  ctl_s   = pin_sync[24:21];
    wire [2:0]  ba_s    = pin_sync[20:18];
    wire [17:0] addr_s  = pin_sync[17:0];

    // command decode
    function automatic smrlro_cmd_type decode_cmd(input logic [3:0] c);
        if (c == 4'h0) begin
            decode_cmd = smrlro_cmd_mode_set;
        end else if (c == 4'h5) begin
            decode_cmd = smrlro_cmd_read;
        end else if (c == 4'h4) begin
            decode_cmd = smrlro_cmd_write;
        end else begin
            decode_cmd = smrlro_cmd_none;
        end
    endfunction : decode_cmd

    // additive latency code to clocks
    function automatic logic [3:0] al_clocks(input logic [1:0] code,
                                             input logic [3:0] cl);
        if (code == 2'h1) begin
            al_clocks = 4'(cl - 4'h1);
        end else if (code == 2'h2) begin
            al_clocks = 4'(cl - 4'h2);
        end else begin
            al_clocks = 4'h0;
        end
    endfunction : al_clocks

    wire smrlro_cmd_type cmd = decode_cmd(ctl_s);
    wire is_read  = (cmd == smrlro_cmd_read);
    wire is_write = (cmd == smrlro_cmd_write);
    wire load_one   = (cmd == smrlro_cmd_mode_set)
                    && (ba_s == `SMRLRO_BA_MODE_ONE);
    wire load_two   = (cmd == smrlro_cmd_mode_set)
                    && (ba_s == `SMRLRO_BA_MODE_TWO);
    wire load_three = (cmd == smrlro_cmd_mode_set)
                    && (ba_s == `SMRLRO_BA_MODE_THREE);

    // first extended register fields kept here
    logic [1:0] al_code;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_leveling <= 1'b0;
            al_code        <= 2'h0;
        end else if (ce && load_one) begin
            write_leveling <= addr_s[`SMRLRO_M1_LEVEL_BIT];
            al_code        <= addr_s[`SMRLRO_M1_AL_HI:`SMRLRO_M1_AL_LO];
        end
    end

    // loaded only by mode set, held otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extended_mode_two   <= `SMRLRO_MODE_TWO_RESET;
            extended_mode_three <= `SMRLRO_MODE_THREE_RESET;
        end else if (ce) begin
            if (load_two) begin
                extended_mode_two <= addr_s;
            end
            if (load_three) begin
                extended_mode_three <= addr_s;
            end
        end
    end

    wire [2:0] cwl_code = addr_s[`SMRLRO_M2_CWL_HI:`SMRLRO_M2_CWL_LO];
    wire       cwl_ok   = (cwl_code <= `SMRLRO_CWL_MAX_CODE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_cas_latency     <= `SMRLRO_CWL_RESET;
            write_cas_unsupported <= 1'b0;
        end else if (ce && load_two) begin
            write_cas_unsupported <= !cwl_ok;
            if (cwl_ok) begin
                write_cas_latency <= 4'(`SMRLRO_CWL_MIN + {1'b0, cwl_code});
            end
        end
    end

    wire [3:0] al_now = al_clocks(al_code, read_cas_latency);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            additive_latency    <= 4'h0;
            total_read_latency  <= 5'h00;
            total_write_latency <= 5'h00;
        end else if (ce) begin
            additive_latency    <= al_now;
            total_read_latency  <= 5'({1'b0, al_now}
                                      + {1'b0, read_cas_latency});
            total_write_latency <= 5'({1'b0, al_now}
                                      + {1'b0, write_cas_latency});
        end
    end

    // additive latency hold of column commands
    wire [1:0] al_out;
    wire [1:0] release_now = (al_now == 4'h0) ? {is_read, is_write}
                                              : al_out;

    smrlro_delay_mem #(.WIDTH(2)) al_line (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .delay   (al_now),
        .wr_data ({is_read, is_write}),
        .rd_data (al_out)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            released_read  <= 1'b0;
            released_write <= 1'b0;
        end else if (ce) begin
            released_read  <= release_now[1];
            released_write <= release_now[0];
        end
    end

    // read data after cas latency from release
    smrlro_delay_mem #(.WIDTH(1)) cl_line (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .delay   (read_cas_latency),
        .wr_data (released_read),
        .rd_data (read_data_start)
    );

    // write data after write cas latency from release
    smrlro_delay_mem #(.WIDTH(1)) cwl_line (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .delay   (write_cas_latency),
        .wr_data (released_write),
        .rd_data (write_data_start)
    );
    // marker one clock before first beat
    wire write_pre;
    smrlro_delay_mem #(.WIDTH(1)) cwl_pre_line (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .delay   (4'(write_cas_latency - 4'h1)),
        .wr_data (released_write),
        .rd_data (write_pre)
    );

    // self refresh rate selection
    wire auto_rate   = extended_mode_two[`SMRLRO_M2_AUTO_BIT];
    wire forced_rate = extended_mode_two[`SMRLRO_M2_FORCED_BIT];
    wire next_double = forced_rate || (auto_rate && hot_s);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selfrefresh_double <= 1'b0;
        end else if (ce) begin
            selfrefresh_double <= next_double;
        end
    end

    wire [1:0] wrt_sel = extended_mode_two[`SMRLRO_M2_WRT_HI:`SMRLRO_M2_WRT_LO];
    wire dyn_en = (wrt_sel != 2'h0) && !write_leveling;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dynamic_termination_en <= 1'b0;
            write_termination      <= 2'h0;
        end else if (ce) begin
            dynamic_termination_en <= dyn_en;
            write_termination      <= wrt_sel;
        end
    end

    // write burst tracking for termination
    smrlro_odt_state_type odt_state;
    smrlro_odt_state_type next_odt_state;
    logic [2:0]           burst_cnt;
    logic [2:0]           next_burst_cnt;

    always_comb begin
        next_odt_state = odt_state;
        next_burst_cnt = burst_cnt;
        case (odt_state)
            smrlro_odt_idle: begin
                if (write_pre) begin
                    next_odt_state = smrlro_odt_burst;
                    next_burst_cnt = `SMRLRO_BURST_CLOCKS;
                end
            end
            smrlro_odt_burst: begin
                if (write_pre) begin
                    next_burst_cnt = `SMRLRO_BURST_CLOCKS;
                end else if (burst_cnt == 3'h1) begin
                    next_odt_state = smrlro_odt_idle;
                    next_burst_cnt = 3'h0;
                end else begin
                    next_burst_cnt = 3'(burst_cnt - 3'h1);
                end
            end
            default: begin
                next_odt_state = smrlro_odt_idle;
                next_burst_cnt = 3'h0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            odt_state <= smrlro_odt_idle;
            burst_cnt <= 3'h0;
        end else if (ce) begin
            odt_state <= next_odt_state;
            burst_cnt <= next_burst_cnt;
        end
    end

    // write value in burst, nominal or off otherwise
    wire in_burst = (next_odt_state == smrlro_odt_burst);
    wire smrlro_term_type next_term =
        (in_burst && dyn_en)   ? smrlro_term_write   :
        nominal_termination_en ? smrlro_term_nominal :
                                 smrlro_term_off;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            termination_select <= smrlro_term_off;
        end else if (ce) begin
            termination_select <= next_term;
        end
    end

    // pattern register routing
    wire pat_en = extended_mode_three[`SMRLRO_M3_PATTERN_BIT];
    // mode bits ignored when pattern is off
    wire [1:0] pat_mode = pat_en
        ? extended_mode_three[`SMRLRO_M3_MODE_HI:`SMRLRO_M3_MODE_LO]
        : 2'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            calibration_pattern_register <= 1'b0;
            pattern_mode                 <= 2'h0;
            pattern_read                 <= 1'b0;
        end else if (ce) begin
            calibration_pattern_register <= pat_en;
            pattern_mode                 <= pat_mode;
            pattern_read                 <= pat_en && release_now[1];
        end
    end
endmodule : smrlro_mode_regs

// [src/smrlro_params.svh]
// constants for the mode register latency, refresh and termination block
`ifndef SMRLRO_PARAMS_SVH
`define SMRLRO_PARAMS_SVH

// bank address codes of the mode register set command
`define SMRLRO_BA_MODE_ONE      3'h1
`define SMRLRO_BA_MODE_TWO      3'h2
`define SMRLRO_BA_MODE_THREE    3'h3

// first extended register fields
`define SMRLRO_M1_LEVEL_BIT     7
`define SMRLRO_M1_AL_HI         4
`define SMRLRO_M1_AL_LO         3

// second extended register fields
`define SMRLRO_M2_CWL_HI        5
`define SMRLRO_M2_CWL_LO        3
`define SMRLRO_M2_AUTO_BIT      6
`define SMRLRO_M2_FORCED_BIT    7
`define SMRLRO_M2_WRT_HI        10
`define SMRLRO_M2_WRT_LO        9

// third extended register fields
`define SMRLRO_M3_PATTERN_BIT   2
`define SMRLRO_M3_MODE_HI       1
`define SMRLRO_M3_MODE_LO       0

// reset values of the stored registers
`define SMRLRO_MODE_TWO_RESET   18'h00000
`define SMRLRO_MODE_THREE_RESET 18'h00000
`define SMRLRO_CWL_RESET        4'h5

// write cas latency lookup: code 0 gives the minimum, highest legal code
`define SMRLRO_CWL_MIN          4'h5
`define SMRLRO_CWL_MAX_CODE     3'h5

// clocks that a burst of eight occupies on the data bus
`define SMRLRO_BURST_CLOCKS     3'h4

`endif

// [src/smrlro_pkg.sv]
// types for the mode register latency, refresh and termination block
package smrlro_pkg;

    typedef enum logic [1:0] {
        smrlro_cmd_none,
        smrlro_cmd_mode_set,
        smrlro_cmd_read,
        smrlro_cmd_write
    } smrlro_cmd_type;

    typedef enum logic [1:0] {
        smrlro_term_off,
        smrlro_term_nominal,
        smrlro_term_write
    } smrlro_term_type;

    typedef enum logic {
        smrlro_odt_idle,
        smrlro_odt_burst
    } smrlro_odt_state_type;

endpackage : smrlro_pkg

// [testbench/smrlro_ctrl_model.sv]
// controller model that drives the command pins of the block
`timescale 1ns/1ps
module smrlro_ctrl_model #(
    parameter int MOD_CLOCKS = 8,
    parameter bit EARLY_DIE  = 1'b0
) (
    // clock
    input  wire logic        clk,
    // command pins
    output logic             cs_b,
    output logic             ras_b,
    output logic             cas_b,
    output logic             we_b,
    output logic [2:0]       ba,
    output logic [17:0]      addr
);
    initial begin
        {cs_b, ras_b, cas_b, we_b} = 4'hf;
        ba = 3'h0;
        addr = 18'h00000;
    end
    // no row commands, so activate spacing holds
    // one command cycle, then deselect with the bus inverted
    task automatic issue(input logic [3:0] pins, input logic [2:0] b,
                         input logic [17:0] a);
        @(posedge clk);
        #1;
        {cs_b, ras_b, cas_b, we_b} = pins;
        ba = b;
        addr = a;
        @(posedge clk);
        #1;
        {cs_b, ras_b, cas_b, we_b} = 4'hf;
        ba = ~b;
        addr = ~a;
    endtask : issue
    task automatic mode_set(input logic [2:0] b, input logic [17:0] a);
        logic [17:0] v;
        v = a;
        if (b == 3'h2) v = v & 18'h186f8;
        if (b == 3'h3) v = v & 18'h18007;
        if (b == 3'h2 && v[7]) v[6] = 1'b0;
        // early die keeps automatic rate off
        if (EARLY_DIE && b == 3'h2) v[6] = 1'b0;
        issue(4'h0, b, v);
        repeat (MOD_CLOCKS) @(posedge clk);
        #1;
    endtask : mode_set
endmodule : smrlro_ctrl_model

// [testbench/smrlro_monitor.sv]
// assertion checker for the mode register block
`timescale 1ns/1ps
`include "smrlro_params.svh"
module smrlro_monitor
    import smrlro_pkg::*;
(
    // clock, reset and enable
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        ce,
    // command pins and read cas latency setting
    input wire logic        cs_b,
    input wire logic        ras_b,
    input wire logic        cas_b,
    input wire logic        we_b,
    input wire logic [2:0]  ba,
    input wire logic [17:0] addr,
    input wire logic [3:0]  read_cas_latency,
    // outputs watched
    input wire logic [3:0]  additive_latency,
    input wire logic [3:0]  write_cas_latency,
    input wire logic [4:0]  total_read_latency,
    input wire logic [17:0] extended_mode_two,
    input wire logic        write_leveling,
    input wire logic        selfrefresh_double,
    input wire logic        dynamic_termination_en,
    input smrlro_term_type  termination_select,
    input wire logic        released_read,
    input wire logic        released_write,
    input wire logic        read_data_start,
    input wire logic        write_data_start,
    input wire logic        calibration_pattern_register,
    input wire logic [1:0]  pattern_mode,
    input wire logic        pattern_read
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [17:0] cmd_hist;
    logic [15:0] rd_hist;
    logic [15:0] wr_hist;
    wire is_read = !cs_b && ras_b && !cas_b && we_b;
    wire is_mset = !cs_b && !ras_b && !cas_b && !we_b;
    // history of read commands and releases, one bit per clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_hist <= 18'h00000;
            rd_hist  <= 16'h0000;
            wr_hist  <= 16'h0000;
        end else begin
            cmd_hist <= {cmd_hist[16:0], is_read};
            rd_hist  <= {rd_hist[14:0], released_read};
            wr_hist  <= {wr_hist[14:0], released_write};
        end
    end
    a_forced_rate_double: assert property (
        (ce && extended_mode_two[7]) |=> selfrefresh_double)
        else $error("forced rate without double refresh");
    a_no_rate_single: assert property (
        (ce && extended_mode_two[7:6] == 2'h0) |=> !selfrefresh_double)
        else $error("double refresh with both rate bits clear");
    a_dyn_term_enable: assert property (
        ce |=> dynamic_termination_en ==
               ($past(extended_mode_two[10:9]) != 2'h0
                && !$past(write_leveling)))
        else $error("dynamic termination enable wrong");
    a_read_sum_steady: assert property (
        ($stable(additive_latency) && $stable(read_cas_latency)) [*4]
        |-> total_read_latency ==
            5'(additive_latency) + 5'(read_cas_latency))
        else $error("read latency sum wrong");
    a_mode_two_load: assert property (
        (is_mset && ba == `SMRLRO_BA_MODE_TWO)
        |-> ##3 extended_mode_two == $past(addr, 3))
        else $error("second register not loaded");
    a_other_ba_kept: assert property (
        (is_mset && ba != `SMRLRO_BA_MODE_TWO)
        |-> ##3 $stable(extended_mode_two))
        else $error("second register changed by other load");
    a_read_release_al: assert property (
        released_read == cmd_hist[5'(additive_latency) + 5'h2])
        else $error("read release not after additive latency");
    a_read_data_time: assert property (
        read_data_start == rd_hist[read_cas_latency - 4'h1])
        else $error("read data start off");
    a_write_data_time: assert property (
        write_data_start == wr_hist[write_cas_latency - 4'h1])
        else $error("write data start off");
    a_pattern_route: assert property (
        pattern_read == (released_read && calibration_pattern_register))
        else $error("pattern read not with release");
    a_pattern_ignored: assert property (
        (!calibration_pattern_register && $past(!calibration_pattern_register))
        |-> pattern_mode == 2'h0)
        else $error("pattern mode seen while disabled");
    a_leveling_no_dyn: assert property (
        (write_leveling && $past(write_leveling))
        |-> termination_select != smrlro_term_write)
        else $error("write termination during leveling");
    c_write_release: cover property (released_write);
    c_pattern_read: cover property (pattern_read);
    c_auto_double: cover property (selfrefresh_double && !extended_mode_two[7]);
endmodule : smrlro_monitor

bind smrlro_mode_regs smrlro_monitor mon_u (.clk, .rst_b, .ce, .cs_b,
    .ras_b, .cas_b, .we_b, .ba, .addr, .read_cas_latency, .additive_latency,
    .write_cas_latency, .total_read_latency, .extended_mode_two,
    .write_leveling, .selfrefresh_double, .dynamic_termination_en,
    .termination_select, .released_read, .released_write, .read_data_start,
    .write_data_start, .calibration_pattern_register, .pattern_mode,
    .pattern_read);

// [testbench/tb_smrlro_mode_regs.sv]
// self-checking testbench for the mode register block
`timescale 1ns/1ps
module tb_smrlro_mode_regs
    import smrlro_pkg::*;
;
    logic clk, rst_b, ce, temp_hot, nominal_termination_en;
    logic cs_b, ras_b, cas_b, we_b;
    logic [2:0] ba;
    logic [17:0] addr, extended_mode_two, extended_mode_three;
    logic [3:0] read_cas_latency, additive_latency, write_cas_latency;
    logic [4:0] total_read_latency, total_write_latency;
    logic write_leveling, write_cas_unsupported, selfrefresh_double;
    logic dynamic_termination_en, released_read, released_write;
    logic read_data_start, write_data_start, pattern_read;
    logic calibration_pattern_register;
    logic [1:0] write_termination, pattern_mode;
    smrlro_term_type termination_select;
    int err_total;
    int checks_done;
    int k;
    logic [3:0] exp_v;

    smrlro_ctrl_model ctrl_u (.clk, .cs_b, .ras_b, .cas_b, .we_b, .ba,
        .addr);
    smrlro_mode_regs dut_u (.clk, .rst_b, .ce, .cs_b, .ras_b, .cas_b, .we_b,
        .ba, .addr, .temp_hot, .read_cas_latency, .nominal_termination_en,
        .write_leveling, .additive_latency, .write_cas_latency,
        .write_cas_unsupported, .total_read_latency, .total_write_latency,
        .extended_mode_two, .extended_mode_three, .selfrefresh_double,
        .dynamic_termination_en, .write_termination, .termination_select,
        .released_read, .released_write, .read_data_start,
        .write_data_start, .calibration_pattern_register, .pattern_mode,
        .pattern_read);

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // count clocks until a pulse shows, bounded
    task automatic cycles_until(ref logic sig, inout int n);
        int lim;
        lim = 0;
        while (sig !== 1'b1 && lim < 40) begin
            @(posedge clk);
            #1;
            n++;
            lim++;
        end
    endtask : cycles_until
    task automatic write_term(input smrlro_term_type in_b,
                              input smrlro_term_type after);
        int n;
        ctrl_u.issue(4'h4, 3'h0, 18'h00000);
        n = 1;
        cycles_until(released_write, n);
        check(18'(n), 18'h9);
        cycles_until(write_data_start, n);
        check(18'(n), 18'he);
        check(termination_select, in_b);
        @(posedge clk);
        #1;
        check(termination_select, in_b);
        repeat (3) @(posedge clk);
        #1;
        check(termination_select, after);
        repeat (4) @(posedge clk);
        #1;
    endtask : write_term

    initial begin
        #100us;
        err_total++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        err_total = 0;
        checks_done = 0;
        rst_b = 1'b0;
        ce = 1'b1;
        temp_hot = 1'b0;
        nominal_termination_en = 1'b1;
        read_cas_latency = 4'h7;
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1'b1;
        check(write_cas_latency, 18'h5);
        check(extended_mode_two, 18'h0);
        repeat (3) @(posedge clk);
        exp_v = 4'h5;
        for (int n = 0; n < 8; n++) begin
            ctrl_u.mode_set(3'h2, 18'(n << 3));
            if (n <= 5) exp_v = 4'(5 + n);
            check(write_cas_latency, exp_v);
            check(write_cas_unsupported, n > 5);
            check(total_write_latency, exp_v);
        end
        $display("write latency codes done");
        for (int c = 0; c < 4; c++) begin
            ctrl_u.mode_set(3'h1, 18'(c << 3));
            exp_v = (c == 1) ? 4'h6 : (c == 2) ? 4'h5 : 4'h0;
            check(additive_latency, exp_v);
            check(total_read_latency, 5'(exp_v) + 5'h7);
        end
        $display("additive latency codes done");
        // forced run, then automatic cold and hot, last hot run sets no rate bit and probes single rate
        for (int i = 0; i < 4; i++) begin
            temp_hot = (i >= 2);
            ctrl_u.mode_set(3'h2, (i == 0) ? 18'h80 : (i == 3) ? 18'h0 :
                                   18'h40);
            check(selfrefresh_double, i == 0 || i == 2);
        end
        temp_hot = 1'b0;
        $display("self refresh rate done");
        ctrl_u.mode_set(3'h1, 18'h00008);
        ctrl_u.mode_set(3'h2, 18'h00200);
        check(extended_mode_two, 18'h00200);
        check(write_termination, 18'h1);
        check(dynamic_termination_en, 18'h1);
        ctrl_u.issue(4'h5, 3'h0, 18'h00000);
        k = 1;
        cycles_until(released_read, k);
        check(18'(k), 18'h9);
        cycles_until(read_data_start, k);
        check(18'(k), 18'h10);
        repeat (4) @(posedge clk);
        write_term(smrlro_term_write, smrlro_term_nominal);
        nominal_termination_en = 1'b0;
        write_term(smrlro_term_write, smrlro_term_off);
        nominal_termination_en = 1'b1;
        ctrl_u.mode_set(3'h1, 18'h00088);
        check(write_leveling, 18'h1);
        write_term(smrlro_term_nominal, smrlro_term_nominal);
        ctrl_u.mode_set(3'h1, 18'h00008);
        $display("read write timing done");
        ctrl_u.mode_set(3'h3, 18'h00005);
        check(calibration_pattern_register, 18'h1);
        check(pattern_mode, 18'h1);
        ctrl_u.issue(4'h5, 3'h0, 18'h00000);
        k = 1;
        cycles_until(pattern_read, k);
        check(18'(k), 18'h9);
        repeat (12) @(posedge clk);
        ctrl_u.mode_set(3'h3, 18'h00003);
        check(extended_mode_three, 18'h00003);
        check(calibration_pattern_register, 18'h0);
        check(pattern_mode, 18'h0);
        ctrl_u.mode_set(3'h0, 18'h3ffff);
        ctrl_u.mode_set(3'h4, 18'h3ffff);
        check(extended_mode_two, 18'h00200);
        check(extended_mode_three, 18'h00003);
        check(write_leveling, 18'h0);
        // enable low: a mode set must be lost
        ce = 1'b0;
        ctrl_u.mode_set(3'h3, 18'h00004);
        ce = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(extended_mode_three, 18'h00003);
        $display("pattern and select done");
        finish_test();
    end
endmodule : tb_smrlro_mode_regs
